// ===== pll_config_and_time_io.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - config byte: range bit, dividend, divisor
// - dividend code zero means thirty-two
// - divisor code zero means five
// - core clock is oscillator times ratio
// - reset setting suits a 20 MHz oscillator
// - startup configuration applied before normal operation
// - console rate scales with the core clock; time-of-day rates are fixed
// - shared pin can show loop locked
// - time-of-day input 8N1, polarity auto-detected
// - missing references are tolerated
// - second pulse width, period, phase, polarity settable
// - time-of-day output at 4800 or 9600
// - frequency output selects 5/10/20/25 MHz
// - duplicate frequency output equals primary
// - syntonized only with steerable source
module pll_config_and_time_io #(
  parameter int IDLE_LEARN_CYC = pll_time_pkg::IDLE_LEARN_CYC,
  parameter int REF_LOSS_CYC   = pll_time_pkg::REF_LOSS_CYC
) (
  // clock, reset, enable
  input  wire logic                     clk_in,
  input  wire logic                     rstn_in,
  input  wire logic                     ce_in,
  // multiplier configuration
  input  wire logic                     startup_cfg_valid_in,
  input  wire logic [7:0]               startup_cfg_in,
  input  wire logic                     cfg_wr_in,
  input  wire logic [7:0]               cfg_wdata_in,
  input  wire logic [5:0]               ext_osc_mhz_in,
  output logic [7:0]                    pll_multiplier_config_out,
  output pll_time_pkg::pll_ratio_t      ratio_out,
  output logic [9:0]                    core_mhz_out,
  output logic [19:0]                   console_baud_out,
  output logic                          range_select_error_out,
  output logic                          boot_done_out,
  // shared pin
  input  wire logic                     pin_lock_mode_in,
  input  wire logic                     pin_gpio_in,
  input  wire logic                     ptp_locked_in,
  output logic                          loop_acquired_flag_out,
  // reference inputs
  input  wire logic                     second_pulse_in,
  input  wire logic                     time_of_day_in,
  input  wire logic                     tod_rx_fast_in,
  output logic                          pps_edge_out,
  output logic                          pps_present_out,
  output logic                          tod_present_out,
  output logic                          tod_inverted_out,
  output logic [7:0]                    tod_rx_byte_out,
  output logic                          tod_rx_valid_out,
  output logic                          tod_rx_frame_err_out,
  // precision time outputs
  input  wire pll_time_pkg::pps_cfg_t   pps_cfg_in,
  input  wire logic                     pps_align_in,
  output logic                          second_pulse_out,
  input  wire logic                     tod_tx_fast_in,
  input  wire logic                     tod_tx_valid_in,
  input  wire logic [7:0]               tod_tx_byte_in,
  output logic                          tod_tx_ready_out,
  output logic                          time_of_day_out,
  // frequency output
  input  wire pll_time_pkg::freq_sel_t  freq_sel_in,
  input  wire logic                     osc_internal_in,
  input  wire logic                     osc_tune_steered_in,
  output pll_time_pkg::freq_sel_t       synced_frequency_out,
  output pll_time_pkg::freq_sel_t       duplicate_frequency_out,
  output logic                          freq_syntonized_out
);
  typedef enum logic {PH_BOOT, PH_RUN} phase_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  // ==========================================================
  // ratio decode, shared by readback and core rate
  function automatic pll_time_pkg::pll_ratio_t decode(input logic [7:0] c);
    pll_time_pkg::pll_ratio_t r;
    logic [4:0] n;
    logic [1:0] m;
    n = c[pll_time_pkg::DIVIDEND_MSB:pll_time_pkg::DIVIDEND_LSB];
    m = c[pll_time_pkg::DIVISOR_MSB:pll_time_pkg::DIVISOR_LSB];
    r.dividend = (n == 5'h00) ? pll_time_pkg::DIVIDEND_ZERO : {1'b0, n};
    r.divisor  = (m == 2'h0) ? pll_time_pkg::DIVISOR_ZERO : {1'b0, m};
    return r;
  endfunction

  // ==========================================================
  // configuration register and phase
  phase_t     ph_q, ph_d;       // boot window or running
  logic [4:0] boot_q, boot_d;   // boot window counter
  logic [7:0] cfg_q, cfg_d;     // multiplier configuration
  logic [9:0] core_q, core_d;   // core clock in MHz
  logic [19:0] baud_q, baud_d;  // effective console rate
  logic [15:0] prod;            // oscillator times dividend

  always_comb begin
    ph_d   = ph_q;
    boot_d = boot_q;
    cfg_d  = cfg_q;
    unique case (ph_q)
      PH_BOOT: begin
        // startup value taken only inside the boot window
        if (startup_cfg_valid_in) cfg_d = startup_cfg_in;
        boot_d = boot_q + 5'h01;
        if (boot_q == 5'(pll_time_pkg::BOOT_CYC - 1)) ph_d = PH_RUN;
      end
      PH_RUN: begin
        // runtime writes store all eight bits
        if (cfg_wr_in) cfg_d = cfg_wdata_in;
      end
    endcase
    // core rate = oscillator * dividend / divisor
    // both factors widened first so the product cannot wrap
    prod   = 16'(ext_osc_mhz_in) * 16'(ratio_out.dividend);
    core_d = 10'(prod / 16'(ratio_out.divisor));
    // console rate follows the core clock
    baud_d = 20'((32'(core_q) * pll_time_pkg::CONSOLE_BAUD) / pll_time_pkg::CORE_MHZ_NOM);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ph_q   <= PH_BOOT;
      boot_q <= 5'h00;
      cfg_q  <= pll_time_pkg::CFG_RESET;
      core_q <= 10'(pll_time_pkg::CORE_MHZ_NOM);
      baud_q <= 20'(pll_time_pkg::CONSOLE_BAUD);
    end else if (ce_in) begin
      ph_q   <= ph_d;
      boot_q <= boot_d;
      cfg_q  <= cfg_d;
      core_q <= core_d;
      baud_q <= baud_d;
    end
  end

  assign pll_multiplier_config_out = cfg_q;
  assign ratio_out                 = decode(cfg_q);
  assign core_mhz_out              = core_q;
  assign console_baud_out          = baud_q;
  assign range_select_error_out    = ~cfg_q[pll_time_pkg::RANGE_BIT];
  assign boot_done_out             = (ph_q == PH_RUN);

  // ==========================================================
  // input synchronisers and reference presence
  logic [2:0]  pps_s_q, tod_s_q;          // three-stage synchronisers
  logic        pps_lvl_q, pps_lvl_d;      // filtered second pulse
  logic        tod_lvl_q, tod_lvl_d;      // filtered time-of-day line
  logic        pps_edge;                  // boundary rising edge
  logic [24:0] pps_age_q, pps_age_d;      // cycles since last edge
  logic [24:0] tod_age_q, tod_age_d;      // cycles since last activity
  logic [15:0] idle_q, idle_d;            // same-level run length
  logic        inv_q, inv_d;              // line idles low

  always_comb begin
    // a change counts once stages two and three agree
    pps_lvl_d = (pps_s_q[1] == pps_s_q[2]) ? pps_s_q[2] : pps_lvl_q;
    tod_lvl_d = (tod_s_q[1] == tod_s_q[2]) ? tod_s_q[2] : tod_lvl_q;
    pps_edge  = pps_lvl_d & ~pps_lvl_q;
    // ages saturate so a dead input just reads absent
    pps_age_d = pps_edge ? 25'h0000000
              : (pps_age_q == 25'(REF_LOSS_CYC)) ? pps_age_q : pps_age_q + 25'h0000001;
    tod_age_d = (tod_lvl_d != tod_lvl_q) ? 25'h0000000
              : (tod_age_q == 25'(REF_LOSS_CYC)) ? tod_age_q : tod_age_q + 25'h0000001;
    // long steady level is the idle level
    idle_d = (tod_lvl_d != tod_lvl_q) ? 16'h0000
           : (idle_q == 16'(IDLE_LEARN_CYC)) ? idle_q : idle_q + 16'h0001;
    inv_d  = (idle_q == 16'(IDLE_LEARN_CYC - 1)) ? ~tod_lvl_q : inv_q;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pps_s_q   <= 3'h0;
      tod_s_q   <= 3'h7;  // serial line idles high, no false start
      pps_lvl_q <= 1'b0;
      tod_lvl_q <= 1'b1;
      pps_age_q <= 25'h0000000;
      tod_age_q <= 25'h0000000;
      idle_q    <= 16'h0000;
      inv_q     <= 1'b0;
    end else if (ce_in) begin
      pps_s_q   <= {pps_s_q[1:0], second_pulse_in};
      tod_s_q   <= {tod_s_q[1:0], time_of_day_in};
      pps_lvl_q <= pps_lvl_d;
      tod_lvl_q <= tod_lvl_d;
      pps_age_q <= pps_age_d;
      tod_age_q <= tod_age_d;
      idle_q    <= idle_d;
      inv_q     <= inv_d;
    end
  end

  assign pps_present_out  = (pps_age_q != 25'(REF_LOSS_CYC));
  assign tod_present_out  = (tod_age_q != 25'(REF_LOSS_CYC));
  assign tod_inverted_out = inv_q;

  // ==========================================================
  // time-of-day receiver, 8N1 on the normalised line
  rx_state_t   rx_q, rx_d;        // receiver state
  logic [11:0] rcnt_q, rcnt_d;    // cycles to next sample
  logic [2:0]  rbit_q, rbit_d;    // data bit index
  logic [7:0]  rsh_q, rsh_d;      // data shift register
  logic [7:0]  rbyte_q, rbyte_d;  // last good byte
  logic        rval_q, rval_d;    // byte valid pulse
  logic        rerr_q, rerr_d;    // framing error pulse
  logic        rx_line;           // line with idle forced high
  logic [11:0] bit_cyc;           // bit length at chosen rate

  always_comb begin
    rx_line = tod_lvl_q ^ inv_q;
    bit_cyc = tod_rx_fast_in ? 12'(pll_time_pkg::BAUD_FAST_CYC - 1)
                             : 12'(pll_time_pkg::BAUD_SLOW_CYC - 1);
    rx_d    = rx_q;
    rcnt_d  = (rcnt_q == 12'h000) ? 12'h000 : rcnt_q - 12'h001;
    rbit_d  = rbit_q;
    rsh_d   = rsh_q;
    rbyte_d = rbyte_q;
    rval_d  = 1'b0;
    rerr_d  = 1'b0;
    unique case (rx_q)
      RX_IDLE: begin
        // start bit: sample again at its middle
        if (!rx_line) begin
          rx_d   = RX_START;
          rcnt_d = {1'b0, bit_cyc[11:1]};
        end
      end
      RX_START: begin
        if (rcnt_q == 12'h000) begin
          rx_d   = rx_line ? RX_IDLE : RX_DATA;
          rcnt_d = bit_cyc;
          rbit_d = 3'h0;
        end
      end
      RX_DATA: begin
        if (rcnt_q == 12'h000) begin
          rsh_d  = {rx_line, rsh_q[7:1]};
          rbit_d = rbit_q + 3'h1;
          rcnt_d = bit_cyc;
          if (rbit_q == 3'h7) rx_d = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rcnt_q == 12'h000) begin
          rx_d = RX_IDLE;
          if (rx_line) begin
            rbyte_d = rsh_q;
            rval_d  = 1'b1;
          end else begin
            rerr_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_q    <= RX_IDLE;
      rcnt_q  <= 12'h000;
      rbit_q  <= 3'h0;
      rsh_q   <= 8'h00;
      rbyte_q <= 8'h00;
      rval_q  <= 1'b0;
      rerr_q  <= 1'b0;
    end else if (ce_in) begin
      rx_q    <= rx_d;
      rcnt_q  <= rcnt_d;
      rbit_q  <= rbit_d;
      rsh_q   <= rsh_d;
      rbyte_q <= rbyte_d;
      rval_q  <= rval_d;
      rerr_q  <= rerr_d;
    end
  end

  assign tod_rx_byte_out      = rbyte_q;
  assign tod_rx_valid_out     = rval_q & ce_in;
  assign tod_rx_frame_err_out = rerr_q & ce_in;

  // ==========================================================
  // second-pulse generator, lock pin, frequency select
  logic [23:0] sec_q, sec_d;     // position within the period
  logic        ppo_q, ppo_d;     // registered pulse output
  logic        edge_q, edge_d;   // registered boundary pulse
  logic        lock_q, lock_d;   // registered shared pin
  logic        synt_q, synt_d;   // syntonized indication
  pll_time_pkg::freq_sel_t fsel_q, fsel_d; // selected frequency
  logic [23:0] rel;              // position past the phase offset

  always_comb begin
    // free runs, realigned by the reference when asked
    sec_d  = (pps_edge && pps_align_in) ? 24'h000000
           : (sec_q >= pps_cfg_in.period - 24'h000001) ? 24'h000000 : sec_q + 24'h000001;
    rel    = sec_q - pps_cfg_in.phase;
    ppo_d  = (rel < pps_cfg_in.width) ^ pps_cfg_in.active_low;
    edge_d = pps_edge;
    lock_d = pin_lock_mode_in ? ptp_locked_in : pin_gpio_in;
    fsel_d = freq_sel_in;
    synt_d = osc_internal_in | osc_tune_steered_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sec_q  <= 24'h000000;
      ppo_q  <= 1'b0;
      edge_q <= 1'b0;
      lock_q <= 1'b0;
      synt_q <= 1'b0;
      fsel_q <= pll_time_pkg::FREQ_10M;
    end else if (ce_in) begin
      sec_q  <= sec_d;
      ppo_q  <= ppo_d;
      edge_q <= edge_d;
      lock_q <= lock_d;
      synt_q <= synt_d;
      fsel_q <= fsel_d;
    end
  end

  assign second_pulse_out        = ppo_q;
  assign pps_edge_out            = edge_q & ce_in;
  assign loop_acquired_flag_out  = lock_q;
  assign synced_frequency_out    = fsel_q;
  assign duplicate_frequency_out = fsel_q;
  assign freq_syntonized_out     = synt_q;

  // time-of-day transmitter
  tod_serial_tx u_tx (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .ce_in     (ce_in),
    .fast_in   (tod_tx_fast_in),
    .valid_in  (tod_tx_valid_in),
    .data_in   (tod_tx_byte_in),
    .ready_out (tod_tx_ready_out),
    .line_out  (time_of_day_out)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_dividend_zero: assert property (cfg_q[6:2] == 5'h00 |-> ratio_out.dividend == 6'h20)
    else $error("dividend code zero not 32");
  a_divisor_zero: assert property (cfg_q[1:0] == 2'h0 |-> ratio_out.divisor == 3'h5)
    else $error("divisor code zero not 5");
  a_boot_capture: assert property (ce_in && ph_q == PH_BOOT && startup_cfg_valid_in |=> cfg_q == $past(startup_cfg_in))
    else $error("startup value not applied");
  a_run_ignores_start: assert property (ce_in && ph_q == PH_RUN && !cfg_wr_in |=> $stable(cfg_q))
    else $error("config changed without a write");
  a_range_flag: assert property (range_select_error_out == !cfg_q[7])
    else $error("range flag wrong");
  a_lock_pin: assert property (ce_in && pin_lock_mode_in |=> loop_acquired_flag_out == $past(ptp_locked_in))
    else $error("lock pin does not follow loop");
  a_dup_freq: assert property (duplicate_frequency_out == synced_frequency_out)
    else $error("duplicate frequency differs");
  a_pps_edge_once: assert property (pps_edge_out |=> !pps_edge_out)
    else $error("boundary pulse longer than one cycle");
  a_core_rate: assert property (ce_in ##1 ce_in |-> core_q == 10'($past(prod) / 16'($past(ratio_out.divisor))))
    else $error("core rate not oscillator times ratio");
  a_syntonized: assert property (ce_in && !osc_internal_in && !osc_tune_steered_in |=> !freq_syntonized_out)
    else $error("syntonized with a fixed oscillator");

  c_boot_cfg: cover property (ph_q == PH_BOOT && startup_cfg_valid_in);
  c_rx_byte: cover property (tod_rx_valid_out);
  c_pps_align: cover property (pps_edge && pps_align_in);
  c_inverted: cover property (inv_q);
endmodule
`default_nettype wire

// ===== pll_config_and_time_io_bench.sv
`timescale 1ns/1ns
`default_nettype none
module pll_config_and_time_io_bench;
  // ==========================================================
  // stimulus and observed signals
  logic clk_in = 1'b0, rstn_in = 1'b0, sv = 0, wr = 0, lm = 0, gp = 0, pl = 0, ce = 1;
  logic pa = 0, txf = 1, txv = 0, oi = 0, os = 0;
  logic [7:0] sc = 0, wd = 0, txb = 0, rxb, rb, b;
  logic [5:0] osc = 6'h14;
  pll_time_pkg::pps_cfg_t pc = '0;
  pll_time_pkg::freq_sel_t fs = pll_time_pkg::FREQ_5M, fy, fd;
  pll_time_pkg::pll_ratio_t ra;
  logic [9:0] core;
  logic [19:0] baud;
  logic re, bd, lf, pe, pp, tp, ti, rv, rf, po, tr, to, sy, ppsl, todl;
  int bad_count = 0, comparisons = 0, n, bc;
  int dv[4] = '{32, 31, 1, 2};
  int ds[4] = '{5, 3, 1, 2};
  always #50 clk_in = ~clk_in;
  time_source_model time_source_model_inst (.clk_in(clk_in), .pps_line_out(ppsl), .tod_line_out(todl));
  pll_config_and_time_io #(.IDLE_LEARN_CYC(5000), .REF_LOSS_CYC(200)) pll_config_and_time_io_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce), .startup_cfg_valid_in(sv), .startup_cfg_in(sc),
    .cfg_wr_in(wr), .cfg_wdata_in(wd), .ext_osc_mhz_in(osc), .pll_multiplier_config_out(rb),
    .ratio_out(ra), .core_mhz_out(core), .console_baud_out(baud), .range_select_error_out(re),
    .boot_done_out(bd), .pin_lock_mode_in(lm), .pin_gpio_in(gp), .ptp_locked_in(pl),
    .loop_acquired_flag_out(lf), .second_pulse_in(ppsl), .time_of_day_in(todl), .tod_rx_fast_in(txf),
    .pps_edge_out(pe), .pps_present_out(pp), .tod_present_out(tp), .tod_inverted_out(ti),
    .tod_rx_byte_out(rxb), .tod_rx_valid_out(rv), .tod_rx_frame_err_out(rf), .pps_cfg_in(pc),
    .pps_align_in(pa), .second_pulse_out(po), .tod_tx_fast_in(txf), .tod_tx_valid_in(txv),
    .tod_tx_byte_in(txb), .tod_tx_ready_out(tr), .time_of_day_out(to), .freq_sel_in(fs),
    .osc_internal_in(oi), .osc_tune_steered_in(os), .synced_frequency_out(fy),
    .duplicate_frequency_out(fd), .freq_syntonized_out(sy));
  // ==========================================================
  // helpers
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic wcfg(input logic [7:0] v);
    wr = 1;
    wd = v;
    cyc(1);
    wr = 0;
    cyc(3);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog well above the roughly 60k cycles of the run
  initial begin
    #8000000;
    bad_count++;
    end_sim();
  end
  // ==========================================================
  // test sequence
  initial begin
    cyc(8);
    rstn_in = 1;
    chk("cfg", rb, 8'hBE);
    chk("core", core, 150);
    chk("boot busy", bd, 0);
    osc = 6'h0A;
    sv = 1;
    sc = 8'hBD;
    cyc(1);
    sv = 0;
    cyc(20);
    chk("boot cfg", rb, 8'hBD);
    chk("boot core", core, 150);
    chk("boot done", bd, 1);
    $display("test reset and boot done");
    for (int i = 0; i < 4; i++) begin
      wcfg(8'h80 | 8'((i == 0) ? 0 : dv[i] << 2) | 8'(i == 0 ? 0 : ds[i]));
      chk("dividend", ra.dividend, dv[i]);
      chk("divisor", ra.divisor, ds[i]);
      chk("core", core, 10 * dv[i] / ds[i]);
    end
    wcfg(8'h3E);
    chk("range", re, 1);
    osc = 6'h0A;
    wcfg(8'hBE);
    chk("baud", baud, 57600);
    $display("test multiplier done");
    ce = 0;
    lm = 1;
    pl = 1;
    cyc(2);
    chk("frozen", lf, 0);
    ce = 1;
    cyc(2);
    chk("lock", lf, 1);
    pl = 0;
    gp = 1;
    cyc(2);
    chk("unlock", lf, 0);
    lm = 0;
    cyc(2);
    chk("gpio", lf, 1);
    for (int i = 0; i < 4; i++) begin
      fs = pll_time_pkg::freq_sel_t'(i[1:0]);
      oi = i[0];
      os = i[1];
      cyc(2);
      chk("freq", fy, i);
      chk("dup", fd, i);
      chk("synt", sy, i != 0);
    end
    $display("test pins done");
    pc = '{24'h14, 24'h5, 24'h0, 1'b0};
    for (int p = 0; p < 2; p++) begin
      cyc(25);
      n = 0;
      repeat (20) begin
        cyc(1);
        n += po;
      end
      chk("pps width", n, p ? 15 : 5);
      pc.active_low = 1;
    end
    pc.phase = 24'h2;
    pa = 1;
    fork
      time_source_model_inst.pulse(3);
    join_none
    n = 0;
    repeat (10) begin
      cyc(1);
      n += pe;
    end
    chk("pps edge", n, 1);
    chk("pps here", pp, 1);
    chk("pps aligned", po, 0);
    cyc(3);
    chk("pps phase", po, 1);
    $display("test second pulse done");
    // fast rate first, then slow, receiver and transmitter alike
    for (int r = 1; r >= 0; r--) begin
      txf = r[0];
      bc = r ? pll_time_pkg::BAUD_FAST_CYC : pll_time_pkg::BAUD_SLOW_CYC;
      txb = r ? 8'hA5 : 8'h5A;
      fork
        time_source_model_inst.send(txb, bc);
      join_none
      cyc(10);
      chk("tod here", tp, 1);
      n = 10;
      while (rv !== 1'b1 && n < 12 * bc) begin
        cyc(1);
        n++;
      end
      chk("rx valid", rv, 1);
      chk("rx byte", rxb, txb);
      chk("rx err", rf, 0);
      chk("rx pol", ti, 0);
      txb = ~txb;
      txv = 1;
      cyc(1);
      txv = 0;
      chk("tx busy", tr, 0);
      n = 0;
      while (to !== 1'b0 && n < 10) begin
        cyc(1);
        n++;
      end
      cyc(bc / 2);
      for (int i = 0; i < 8; i++) begin
        cyc(bc);
        b[i] = to;
      end
      chk("tx byte", b, txb);
      cyc(bc);
      chk("tx stop", to, 1);
    end
    $display("test serial done");
    cyc(300);
    chk("pps lost", pp, 0);
    chk("tod lost", tp, 0);
    $display("test lost reference done");
    end_sim();
  end
endmodule
`default_nettype wire

// ===== pll_time_pkg.sv
`default_nettype none
package pll_time_pkg;

  // ==========================================================
  // clock and baud timing
  localparam int CLK_HZ         = 10_000_000;          // system clock rate
  localparam int BAUD_SLOW      = 4800;                // time-of-day slow rate
  localparam int BAUD_FAST      = 9600;                // time-of-day fast rate
  localparam int BAUD_SLOW_CYC  = CLK_HZ / BAUD_SLOW;  // cycles per slow bit
  localparam int BAUD_FAST_CYC  = CLK_HZ / BAUD_FAST;  // cycles per fast bit
  localparam int FRAME_BITS     = 10;                  // start, 8 data, stop
  localparam int IDLE_LEARN_CYC = FRAME_BITS * BAUD_SLOW_CYC; // polarity learn time
  localparam int REF_LOSS_CYC   = 2 * CLK_HZ;          // reference absent after 2 s
  localparam int BOOT_CYC       = 16;                  // startup configuration window

  // ==========================================================
  // multiplier configuration register layout
  localparam int          RANGE_BIT    = 7;            // range select, must be 1
  localparam int          DIVIDEND_MSB = 6;            // dividend field top
  localparam int          DIVIDEND_LSB = 2;            // dividend field bottom
  localparam int          DIVISOR_MSB  = 1;            // divisor field top
  localparam int          DIVISOR_LSB  = 0;            // divisor field bottom
  localparam logic [7:0]  CFG_RESET    = 8'hBE;        // 15/2 for a 20 MHz oscillator
  localparam logic [5:0]  DIVIDEND_ZERO = 6'h20;       // code 0 means 32
  localparam logic [2:0]  DIVISOR_ZERO  = 3'h5;        // code 0 means 5
  localparam int          CORE_MHZ_NOM  = 150;         // target core clock
  localparam int          OSC_MHZ_NOM   = 20;          // assumed oscillator
  localparam int          CONSOLE_BAUD  = 115_200;     // nominal console rate

  // ==========================================================
  // second-pulse output defaults
  localparam logic [23:0] PPS_PERIOD_RESET = 24'h989680; // one second of cycles
  localparam logic [23:0] PPS_WIDTH_RESET  = 24'h002710; // 1 ms high

  // frequency output selections
  typedef enum logic [1:0] {FREQ_5M, FREQ_10M, FREQ_20M, FREQ_25M} freq_sel_t;

  // software settings of the second-pulse output
  typedef struct packed {
    logic [23:0] period;   // repetition period in cycles
    logic [23:0] width;    // active width in cycles
    logic [23:0] phase;    // offset from the second boundary
    logic        active_low; // polarity
  } pps_cfg_t;

  // decoded multiplier ratio
  typedef struct packed {
    logic [5:0] dividend;  // 1..32
    logic [2:0] divisor;   // 1,2,3,5
  } pll_ratio_t;

endpackage
`default_nettype wire

// ===== time_source_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// external time source: second pulse and serial time-of-day
module time_source_model (
  // clock
  input  wire logic clk_in,
  // reference pins
  output logic      pps_line_out,
  output logic      tod_line_out
);
  // idle levels: pulse low, serial line high
  initial begin
    pps_line_out = 1'b0;
    tod_line_out = 1'b1;
  end
  // rising edge marks the boundary, width is free
  task automatic pulse(input int width);
    @(negedge clk_in) pps_line_out = 1'b1;
    repeat (width) @(negedge clk_in);
    pps_line_out = 1'b0;
  endtask
  // one 8N1 frame, lsb first
  task automatic send(input logic [7:0] b, input int cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_in) tod_line_out = f[i];
      repeat (cyc - 1) @(negedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ===== tod_serial_tx.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// 8N1 serial transmitter for the time-of-day output
module tod_serial_tx (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       ce_in,
  // byte side
  input  wire logic       fast_in,
  input  wire logic       valid_in,
  input  wire logic [7:0] data_in,
  output logic            ready_out,
  // line side
  output logic            line_out
);
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;

  tx_state_t   st_q, st_d;     // transmitter state
  logic [11:0] cnt_q, cnt_d;   // cycles left in bit
  logic [3:0]  bit_q, bit_d;   // bits left in frame
  logic [9:0]  sh_q, sh_d;     // frame shift register
  logic        line_q, line_d; // registered line

  // ==========================================================
  // next state
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    line_d = line_q;
    unique case (st_q)
      TX_IDLE: begin
        line_d = 1'b1;
        // load stop, data lsb first, start
        if (valid_in) begin
          sh_d  = {1'b1, data_in, 1'b0};
          bit_d = 4'(pll_time_pkg::FRAME_BITS);
          cnt_d = 12'h000;
          st_d  = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (cnt_q == 12'h000) begin
          // bit boundary: emit next bit or finish
          if (bit_q == 4'h0) begin
            st_d   = TX_IDLE;
            line_d = 1'b1;
          end else begin
            line_d = sh_q[0];
            sh_d   = {1'b1, sh_q[9:1]};
            bit_d  = bit_q - 4'h1;
            cnt_d  = fast_in ? 12'(pll_time_pkg::BAUD_FAST_CYC - 1)
                             : 12'(pll_time_pkg::BAUD_SLOW_CYC - 1);
          end
        end else begin
          cnt_d = cnt_q - 12'h001;
        end
      end
    endcase
  end

  // registers, frozen while the enable is low
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q   <= TX_IDLE;
      cnt_q  <= 12'h000;
      bit_q  <= 4'h0;
      sh_q   <= 10'h3FF;
      line_q <= 1'b1;
    end else if (ce_in) begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      line_q <= line_d;
    end
  end

  assign ready_out = (st_q == TX_IDLE);
  assign line_out  = line_q;
endmodule
`default_nettype wire
